// *** shared/fpa_pkg.sv ***
// Package: shared constants, types and helpers of the flash prefetch accelerator
`default_nettype none
package fpa_pkg;
    localparam int LINE_W = 128;
    localparam int WORD_W = 32;
    localparam int IDX_W = 12;
    localparam int DIDX_W = 13;
    localparam int ADDR_W = 17;
    localparam int WSEL_LSB = 2;
    localparam int LINE_LSB = 4;
    localparam int CYC_W = 3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PART = 2'h1;
    localparam logic [1:0] MODE_FULL = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [1:0] MODE_RESET = MODE_OFF;
    localparam logic [CYC_W-1:0] CYC_RESET = 3'h7;
    localparam logic [CYC_W-1:0] CYC_NONE = 3'h0;
    localparam logic [1:0] LAST_WORD = 2'h3;

    typedef enum logic [2:0] {
        DST_PF = 3'h1,
        DST_BT = 3'h2,
        DST_DATA = 3'h4
    } fpa_dst_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_HOLD = 3'h4
    } fpa_state_t;

    typedef struct packed {
        logic instr;
        logic seq;
        logic [ADDR_W-1:0] addr;
    } fpa_req_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
        logic [LINE_W-1:0] line;
    } fpa_line_t;

    typedef struct packed {
        fpa_line_t pf;
        fpa_line_t bt;
        logic busy;
        fpa_dst_t dst;
        logic [IDX_W-1:0] idx;
    } fpa_bank_st_t;

    function automatic logic [WORD_W-1:0] fpa_word(input logic [LINE_W-1:0] l,
                                                   input logic [1:0] w);
        return l[w*WORD_W +: WORD_W];
    endfunction

    function automatic logic fpa_hit(input fpa_line_t l, input logic [IDX_W-1:0] i);
        return l.valid && (l.idx == i);
    endfunction

    function automatic logic [IDX_W-1:0] fpa_inc(input logic [IDX_W-1:0] i);
        return IDX_W'(i + 1);
    endfunction
endpackage
`default_nettype wire

// *** hdl/fpa_bank_line.sv ***
// Module: one flash bank access timer with its prefetch and branch-trail lines
`timescale 1ns/10ps
`default_nettype none
module fpa_bank_line (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic inval_i,
    input wire logic start_i,
    input wire fpa_pkg::fpa_dst_t dst_i,
    input wire logic [fpa_pkg::IDX_W-1:0] idx_i,
    input wire logic [fpa_pkg::CYC_W-1:0] cycles_i,
    input wire logic [fpa_pkg::LINE_W-1:0] rdata_i,
    output logic fin_o,
    output fpa_pkg::fpa_bank_st_t st_o,
    output logic flash_rd_o
);
    import fpa_pkg::*;

    typedef struct packed {
        fpa_bank_st_t st;
        logic rd;
        logic [CYC_W-1:0] cnt;
        logic [CYC_W-1:0] len;
        logic [CYC_W-1:0] ran;
    } fpa_bank_t;

    fpa_bank_t s_ff;
    fpa_bank_t nxt_s;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_s = s_ff;
        fin_o = s_ff.st.busy && (s_ff.cnt == CYC_NONE) && !inval_i;
        if (inval_i) begin
            nxt_s.st.pf.valid = 1'b0;
            nxt_s.st.bt.valid = 1'b0;
            nxt_s.st.busy = 1'b0;
            nxt_s.rd = 1'b0;
        end else if (fin_o) begin
            nxt_s.st.busy = 1'b0;
            nxt_s.rd = 1'b0;
            if (s_ff.st.dst == DST_PF) begin
                nxt_s.st.pf = '{valid: 1'b1, idx: s_ff.st.idx, line: rdata_i};
            end else if (s_ff.st.dst == DST_BT) begin
                nxt_s.st.bt = '{valid: 1'b1, idx: s_ff.st.idx, line: rdata_i};
            end
        end else if (s_ff.st.busy) begin
            nxt_s.cnt = s_ff.cnt - 3'h1;
            nxt_s.ran = s_ff.ran + 3'h1;
        end else if (start_i) begin
            nxt_s.st.busy = 1'b1;
            nxt_s.st.dst = dst_i;
            nxt_s.st.idx = idx_i;
            nxt_s.rd = 1'b1;
            nxt_s.cnt = cycles_i - 3'h1;
            nxt_s.len = cycles_i;
            nxt_s.ran = CYC_NONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff <= '{st: '{dst: DST_BT, default: '0}, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign st_o = s_ff.st;
    assign flash_rd_o = s_ff.rd;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_fetch_len: assert property (fin_o |-> s_ff.ran == s_ff.len - 3'h1)
        else $error("flash access length differs from setting");
    a_pf_capture: assert property (
        (fin_o && s_ff.st.dst == DST_PF) |=> st_o.pf.valid && st_o.pf.idx == $past(s_ff.st.idx))
        else $error("prefetch line not captured at end of access");
    a_inval_clear: assert property (inval_i |=> !st_o.pf.valid && !st_o.bt.valid && !st_o.busy)
        else $error("line buffers not invalidated");
endmodule
`default_nettype wire

// *** hdl/fpa_accel.sv ***
// Module: flash prefetch accelerator between core fetch port and two flash banks
//
// Notes on behaviour
// - Two flash banks, each read independently and in parallel.
// - Each bank has its own prefetch line and branch-trail line.
// - Instruction miss with no prefetch under way loads branch-trail lines.
// - A finished speculative prefetch captures one 128-bit line into the bank.
// - A line holds four 32-bit words, selected by address bits 3:2.
// - After the last word of a line, its bank prefetches its next line.
// - Backward branch hitting a branch-trail line needs no flash read.
// - Forward branch hitting a prefetch line is served without delay.
// - Branch missing all lines costs one flash access loading branch-trail lines.
// - One shared 128-bit data line with 13-bit line address.
// - Data miss fetches a four-word line into the data line.
// - Data accesses never start a prefetch.
// - Each instruction line keeps a 12-bit compare address.
// - Per-bank flash address latch; bank 0 has the incrementer.
// - Flash access while flash busy stalls core by dropping clock gate.
// - Start of program or erase invalidates all holding lines.
// - After invalidation the next read fetches anew once flash is free.
// - Program and erase are outside; busy arrives as one level.
// - Mode 00 off, 01 partial, 10 full, 11 ignored; reset off.
// - Any mode change invalidates all holding lines.
// - Flash access lasts 1 to 7 clocks; reset selects 7.
// - Partial mode serves only sequential instruction hits from lines.
`timescale 1ns/10ps
`default_nettype none
module fpa_accel (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] accel_mode_select_i,
    input wire logic [fpa_pkg::CYC_W-1:0] flash_fetch_cycles_i,
    input wire logic flash_busy_i,
    input wire logic req_valid_i,
    input wire fpa_pkg::fpa_req_t req_i,
    input wire logic [1:0][fpa_pkg::LINE_W-1:0] bank_rdata_i,
    output logic resp_valid_o,
    output logic [fpa_pkg::WORD_W-1:0] rdata_o,
    output logic core_clock_gate_o,
    output logic [1:0] bank_rd_o,
    output logic [1:0][fpa_pkg::IDX_W-1:0] bank_idx_o
);
    import fpa_pkg::*;

    typedef struct packed {
        fpa_state_t state;
        fpa_req_t req;
        logic wbank;
        logic [1:0] mode;
        logic [CYC_W-1:0] cyc;
        logic busy_q;
        logic dvalid;
        logic [DIDX_W-1:0] didx;
        logic [LINE_W-1:0] dline;
        logic resp;
        logic [WORD_W-1:0] rdata;
        logic gate;
    } fpa_top_t;

    fpa_top_t s_ff;
    fpa_top_t nxt_s;
    logic [1:0] rs_ff;
    logic rst_n;
    fpa_bank_st_t [1:0] bst;
    logic [1:0] fin;
    logic [1:0] start;
    fpa_dst_t sdst [2];
    logic [1:0][IDX_W-1:0] sidx;
    logic inval;
    logic act;
    fpa_req_t cur;
    logic [DIDX_W-1:0] lidx;
    logic b;
    logic [IDX_W-1:0] bidx;
    logic [1:0] wsel;
    logic use_lat;
    logic pf_hit;
    logic bt_hit;
    logic d_hit;
    logic pend;
    logic [WORD_W-1:0] hit_word;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rs_ff <= 2'h0;
        end else begin
            rs_ff <= {rs_ff[0], 1'b1};
        end
    end
    assign rst_n = rs_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Banks
    for (genvar k = 0; k < 2; k++) begin : g_bank
        fpa_bank_line u_bank (
            .clk_i(ref_clk_i),
            .rst_n_i(rst_n),
            .inval_i(inval),
            .start_i(start[k]),
            .dst_i(sdst[k]),
            .idx_i(sidx[k]),
            .cycles_i(s_ff.cyc),
            .rdata_i(bank_rdata_i[k]),
            .fin_o(fin[k]),
            .st_o(bst[k]),
            .flash_rd_o(bank_rd_o[k])
        );
        assign bank_idx_o[k] = bst[k].idx;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lookup and control
    always_comb begin
        nxt_s = s_ff;
        nxt_s.resp = 1'b0;
        start = 2'h0;
        sdst[0] = DST_BT;
        sdst[1] = DST_BT;
        sidx = '0;
        if (accel_mode_select_i != MODE_RSVD) begin
            nxt_s.mode = accel_mode_select_i;
        end
        if (flash_fetch_cycles_i != CYC_NONE) begin
            nxt_s.cyc = flash_fetch_cycles_i;
        end
        nxt_s.busy_q = flash_busy_i;
        inval = (nxt_s.mode != s_ff.mode) || (flash_busy_i && !s_ff.busy_q);
        if (inval) begin
            nxt_s.dvalid = 1'b0;
        end
        cur = (s_ff.state == ST_IDLE) ? req_i : s_ff.req;
        act = (s_ff.state == ST_HOLD) || ((s_ff.state == ST_IDLE) && req_valid_i);
        lidx = cur.addr[ADDR_W-1:LINE_LSB];
        b = lidx[0];
        bidx = lidx[DIDX_W-1:1];
        wsel = cur.addr[LINE_LSB-1:WSEL_LSB];
        use_lat = cur.instr ? ((s_ff.mode == MODE_FULL) ||
                               ((s_ff.mode == MODE_PART) && cur.seq))
                            : (s_ff.mode == MODE_FULL);
        pf_hit = cur.instr && use_lat && fpa_hit(bst[b].pf, bidx);
        bt_hit = cur.instr && use_lat && fpa_hit(bst[b].bt, bidx);
        d_hit = !cur.instr && use_lat && s_ff.dvalid && (s_ff.didx == lidx);
        pend = cur.instr && use_lat && bst[b].busy &&
               (bst[b].dst == DST_PF) && (bst[b].idx == bidx);
        hit_word = fpa_word(d_hit ? s_ff.dline : (pf_hit ? bst[b].pf.line : bst[b].bt.line),
                            wsel);
        case (s_ff.state)
            ST_IDLE, ST_HOLD: begin
                nxt_s.gate = 1'b1;
                if (act) begin
                    nxt_s.req = cur;
                    nxt_s.gate = 1'b0;
                    nxt_s.wbank = b;
                    if (flash_busy_i || inval) begin
                        nxt_s.state = ST_HOLD;
                    end else if (pf_hit || bt_hit || d_hit) begin
                        nxt_s.state = ST_IDLE;
                        nxt_s.gate = 1'b1;
                        nxt_s.resp = 1'b1;
                        nxt_s.rdata = hit_word;
                        if (cur.instr && (wsel == LAST_WORD) && !bst[b].busy) begin
                            start[b] = 1'b1;
                            sdst[b] = DST_PF;
                            sidx[b] = fpa_inc(bidx);
                        end
                    end else if (pend && fin[b]) begin
                        nxt_s.state = ST_HOLD;
                    end else if (pend) begin
                        nxt_s.state = ST_WAIT;
                    end else if (!bst[0].busy && !bst[1].busy) begin
                        nxt_s.state = ST_WAIT;
                        start[b] = 1'b1;
                        sidx[b] = bidx;
                        if (!cur.instr) begin
                            sdst[b] = DST_DATA;
                        end else begin
                            start[!b] = 1'b1;
                            sidx[!b] = b ? fpa_inc(bidx) : bidx;
                        end
                    end else begin
                        nxt_s.state = ST_HOLD;
                    end
                end
            end
            ST_WAIT: begin
                if (inval) begin
                    nxt_s.state = ST_HOLD;
                end else if (fin[s_ff.wbank]) begin
                    nxt_s.state = ST_IDLE;
                    nxt_s.gate = 1'b1;
                    nxt_s.resp = 1'b1;
                    nxt_s.rdata = fpa_word(bank_rdata_i[s_ff.wbank], wsel);
                    if (!s_ff.req.instr) begin
                        nxt_s.dvalid = 1'b1;
                        nxt_s.didx = lidx;
                        nxt_s.dline = bank_rdata_i[s_ff.wbank];
                    end
                end
            end
            default: begin
                nxt_s.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '{state: ST_IDLE, mode: MODE_RESET, cyc: CYC_RESET, gate: 1'b1,
                      default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign resp_valid_o = s_ff.resp;
    assign rdata_o = s_ff.rdata;
    assign core_clock_gate_o = s_ff.gate;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    a_rsvd_mode_kept: assert property (
        accel_mode_select_i == MODE_RSVD |=> s_ff.mode == $past(s_ff.mode))
        else $error("reserved mode code changed the mode");
    a_mode_inval: assert property (
        (nxt_s.mode != s_ff.mode) |=> !s_ff.dvalid && !bst[0].pf.valid && !bst[1].bt.valid)
        else $error("mode change left lines valid");
    a_prog_inval: assert property ($rose(flash_busy_i) |=> !s_ff.dvalid && !bst[1].pf.valid)
        else $error("program start left lines valid");
    a_busy_stall: assert property (
        (act && flash_busy_i) |=> !core_clock_gate_o && !resp_valid_o)
        else $error("flash busy did not stall the core");
    a_bt_hit: assert property (
        (act && bt_hit && !pf_hit && !flash_busy_i && !inval) |->
        (!start[!b] && (!start[b] || sdst[b] == DST_PF)) ##1 (resp_valid_o && core_clock_gate_o))
        else $error("branch-trail hit was not served at once");
    a_pf_hit: assert property (
        (act && pf_hit && !flash_busy_i && !inval) |=> resp_valid_o && rdata_o == $past(hit_word))
        else $error("prefetch hit delivered late or wrong");
    a_data_no_pf: assert property (
        (start[0] && sdst[0] == DST_PF) || (start[1] && sdst[1] == DST_PF) |-> cur.instr)
        else $error("prefetch started for a data access");
    a_data_miss: assert property (
        (act && !cur.instr && !d_hit && !flash_busy_i && !inval && start[b])
        |=> !core_clock_gate_o ##[1:7] resp_valid_o)
        else $error("data miss not answered within the access time");
    a_part_nonseq: assert property (
        (act && s_ff.mode == MODE_PART && !cur.seq && !flash_busy_i) |=> !resp_valid_o)
        else $error("partial mode served a non-sequential access from a line");
    a_bank0_inc: assert property (
        (start[0] && start[1] && b && act) |-> sidx[0] == fpa_inc(bidx))
        else $error("bank 0 next line address wrong");

    c_hit: cover property (act && (pf_hit || bt_hit) ##1 resp_valid_o);
    c_miss: cover property (act && start[0] && start[1] ##[2:9] resp_valid_o);
    c_stall: cover property (act && flash_busy_i ##1 !core_clock_gate_o);
    c_prefetch: cover property (start[b] && sdst[b] == DST_PF);
endmodule
`default_nettype wire

// *** test/fpa_flash_model.sv ***
// Flash bank model: answers line reads of both banks from the line address
`timescale 1ns/10ps
`default_nettype none
module fpa_flash_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] rd_i,
    input wire logic [1:0][fpa_pkg::IDX_W-1:0] idx_i,
    output logic [1:0][fpa_pkg::LINE_W-1:0] rdata_o
);
    import fpa_pkg::*;
    logic [7:0] noise_ff;
    logic [7:0] nxt_noise;
    logic [WORD_W-1:0] wd;
    ////////////////////////////////////////////////////////////////////////
    // Banks answer independently; idle banks show a changing pattern
    always_comb begin
        nxt_noise = noise_ff + 8'h35;
        wd = '0;
        for (int k = 0; k < 2; k++) begin
            for (int w = 0; w < 4; w++) begin
                wd = {8'hF1, 7'h00, idx_i[k], k[0], w[1:0], 2'h0};
                rdata_o[k][w*WORD_W +: WORD_W] = rd_i[k] ? wd : {4{noise_ff}};
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            noise_ff <= 8'h5A;
        end else begin
            noise_ff <= nxt_noise;
        end
    end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Testbench: flash prefetch accelerator against a flash bank model
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import fpa_pkg::*;
    localparam logic [16:0] BASE_I = 17'h00100;
    localparam logic [16:0] BASE_D = 17'h04010;
    logic ref_clk_i;
    logic reset_n_i;
    logic [1:0] accel_mode_select_i;
    logic [CYC_W-1:0] flash_fetch_cycles_i;
    logic flash_busy_i;
    logic req_valid_i;
    fpa_req_t req_i;
    logic [1:0][LINE_W-1:0] bank_rdata_i;
    logic resp_valid_o;
    logic [WORD_W-1:0] rdata_o;
    logic core_clock_gate_o;
    logic [1:0] bank_rd_o;
    logic [1:0][IDX_W-1:0] bank_idx_o;
    logic [1:0] rd_seen;
    logic [1:0][IDX_W-1:0] idx_seen;
    logic [WORD_W-1:0] exp_q[$];
    logic [31:0] r;
    int checks = 0;
    int num_errors = 0;
    int last_lat = 0;
    int cyc_cnt = 0;
    ////////////////////////////////////////////////////////////////////////
    fpa_accel i_dut (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .accel_mode_select_i(accel_mode_select_i),
        .flash_fetch_cycles_i(flash_fetch_cycles_i),
        .flash_busy_i(flash_busy_i),
        .req_valid_i(req_valid_i),
        .req_i(req_i),
        .bank_rdata_i(bank_rdata_i),
        .resp_valid_o(resp_valid_o),
        .rdata_o(rdata_o),
        .core_clock_gate_o(core_clock_gate_o),
        .bank_rd_o(bank_rd_o),
        .bank_idx_o(bank_idx_o)
    );
    fpa_flash_model i_flash (
        .clk_i(ref_clk_i),
        .rst_n_i(reset_n_i),
        .rd_i(bank_rd_o),
        .idx_i(bank_idx_o),
        .rdata_o(bank_rdata_i)
    );
    ////////////////////////////////////////////////////////////////////////
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            num_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Expected word of a byte address
    function automatic logic [WORD_W-1:0] fw(input logic [16:0] a);
        return {8'hF1, 7'h00, a[16:2], 2'h0};
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic setm(input logic [1:0] m, input logic [CYC_W-1:0] c);
        @(posedge ref_clk_i);
        accel_mode_select_i <= m;
        flash_fetch_cycles_i <= c;
        repeat (3) @(posedge ref_clk_i);
    endtask
    // One core access; latency counted from the taking edge
    task automatic req(input logic ins, input logic sq, input logic [16:0] a, input int exp_lat);
        int lat;
        lat = 0;
        exp_q.push_back(fw(a));
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{instr: ins, seq: sq, addr: a};
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        rd_seen = 2'h0;
        do begin
            @(negedge ref_clk_i);
            lat++;
            if (rd_seen == 2'h0) idx_seen = bank_idx_o;
            rd_seen = rd_seen | bank_rd_o;
            if (resp_valid_o !== 1'b1) check(core_clock_gate_o, 1'b0);
        end while (resp_valid_o !== 1'b1 && lat < 60);
        check(rdata_o, exp_q.pop_front());
        if (exp_lat > 0) check(lat, exp_lat);
        last_lat = lat;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        reset_n_i = 1'b0;
        accel_mode_select_i = MODE_OFF;
        flash_fetch_cycles_i = CYC_NONE;
        flash_busy_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        void'($urandom(32'hA07E));
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        req(1'b1, 1'b0, BASE_I, 8);
        for (int n = 1; n < 8; n++) begin
            setm(MODE_OFF, 3'(n));
            req(1'b1, 1'b1, BASE_I, n + 1);
        end
        $display("test done: mode off timing");
        setm(MODE_FULL, 3'h2);
        req(1'b1, 1'b0, BASE_I, 3);
        check(rd_seen, 2'h3);
        check(idx_seen, {12'h008, 12'h008});
        for (int w = 1; w < 8; w++) begin
            req(1'b1, 1'b1, BASE_I + 17'(4 * w), 1);
            if (w == 3) check(idx_seen[0], 12'h009);
            if (w == 3) check(rd_seen, 2'h1);
        end
        req(1'b1, 1'b1, BASE_I + 17'h20, 1);
        req(1'b1, 1'b0, BASE_I + 17'h4, 1);
        check(rd_seen, 2'h0);
        req(1'b1, 1'b0, BASE_I + 17'h34, 1);
        req(1'b1, 1'b0, BASE_I + 17'h1000, 3);
        req(1'b1, 1'b1, BASE_I + 17'h100C, 1);
        check(rd_seen, 2'h1);
        req(1'b1, 1'b1, BASE_I + 17'h1020, 2);
        setm(MODE_FULL, 3'h4);
        req(1'b1, 1'b1, BASE_I + 17'h102C, 1);
        req(1'b1, 1'b1, BASE_I + 17'h1040, 3);
        check(rd_seen, 2'h1);
        check(idx_seen[0], 12'h08A);
        setm(MODE_FULL, 3'h2);
        req(1'b1, 1'b0, BASE_I + 17'h2010, 3);
        check(rd_seen, 2'h3);
        check(idx_seen, {12'h108, 12'h109});
        req(1'b1, 1'b1, BASE_I + 17'h2020, 1);
        $display("test done: full mode code");
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            req(1'b0, 1'b0, {1'b1, r[15:2], 2'h0}, 3);
            check(rd_seen, {r[4], ~r[4]});
            req(1'b0, 1'b1, {1'b1, r[15:2], 2'h0} ^ 17'h0000C, 1);
        end
        $display("test done: full mode data");
        setm(MODE_PART, 3'h2);
        req(1'b1, 1'b1, BASE_I + 17'h1004, 3);
        req(1'b1, 1'b1, BASE_I + 17'h1008, 1);
        req(1'b1, 1'b0, BASE_I + 17'h1000, 3);
        req(1'b0, 1'b0, BASE_D, 3);
        req(1'b0, 1'b0, BASE_D, 3);
        setm(MODE_RSVD, 3'h2);
        req(1'b1, 1'b1, BASE_I + 17'h1008, 1);
        $display("test done: partial mode");
        setm(MODE_FULL, 3'h2);
        req(1'b1, 1'b1, BASE_I + 17'h1008, 3);
        req(1'b1, 1'b0, BASE_I + 17'h1004, 1);
        @(posedge ref_clk_i);
        flash_busy_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        flash_busy_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        req(1'b1, 1'b0, BASE_I + 17'h1004, 3);
        @(posedge ref_clk_i);
        flash_busy_i <= 1'b1;
        fork
            req(1'b1, 1'b0, BASE_I + 17'h1008, 0);
            begin
                repeat (12) @(posedge ref_clk_i);
                flash_busy_i <= 1'b0;
            end
        join
        check(last_lat > 10, 1'b1);
        check(last_lat < 17, 1'b1);
        $display("test done: flash busy");
        conclude();
    end
endmodule
`default_nettype wire
